// ==== common/hall_store_pkg.sv ====
// Summary of operation
// - Programming only by supply modulation; analog in band
// - Valid command accesses memory, then answers digitally
// - Only the pin-selected device acts on commands
// - Registers form magnet, output and trim/lock groups
// - Mode bits 2:1 pick 30/60/80/100 mT range
// - Two-bit band picks linear temperature compensation span
// - Gain word is the signed processing multiplier
// - Offset word is the signed processing adder term
// - Lower clamp sets floor, zero to half supply
// - Upper clamp sets ceiling, zero to full supply
// - Processed value readable through its readout register
// - Lock bit set: all later commands are ignored
// - Lock applies only after the next power cycle
// - Lock is permanent; programming disabled for ever
`default_nettype none
package hall_store_pkg;
   // Word and address geometry of the parameter store
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int N_WORDS = 11;
   // Group 1: magnet adaption
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_TC_LIN = 4'h1;
   localparam logic [3:0] ADDR_TC_QUAD = 4'h2;
   localparam logic [3:0] ADDR_TC_BAND = 4'h3;
   // Group 2: output transfer
   localparam logic [3:0] ADDR_GAIN = 4'h4;
   localparam logic [3:0] ADDR_OFFSET = 4'h5;
   localparam logic [3:0] ADDR_CLAMP_LO = 4'h6;
   localparam logic [3:0] ADDR_CLAMP_HI = 4'h7;
   // Group 3: lock and factory trim, plus the readout
   localparam logic [3:0] ADDR_LOCK = 4'h8;
   localparam logic [3:0] ADDR_READOUT = 4'h9;
   localparam logic [3:0] ADDR_TRIM = 4'hA;
   // Field positions
   localparam int MODE_RANGE_LSB = 1;
   localparam int MODE_RANGE_MSB = 2;
   localparam int MODE_FILT_LSB = 3;
   localparam int MODE_FILT_MSB = 5;
   localparam int LOCK_W = 2;
   localparam int LOCK_BIT = 0;
   // Processing widths: gain 1/2048 steps, offset and output Vdd/1024 steps
   localparam int FIELD_W = 16;
   localparam int GAIN_W = 14;
   localparam int OFFSET_W = 11;
   localparam int CLO_W = 8;
   localparam int CHI_W = 9;
   localparam int OUT_W = 10;
   localparam int PROD_W = FIELD_W + GAIN_W;
   localparam int PROD_SHIFT = 17;
   localparam int SUM_W = 14;
   // Reset values
   localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
   localparam logic [OUT_W-1:0] OUT_RST = 10'h000;

   typedef enum logic [1:0] {
      RANGE_30MT = 2'b00,
      RANGE_60MT = 2'b01,
      RANGE_80MT = 2'b10,
      RANGE_100MT = 2'b11
   } field_range_t;

   typedef enum logic [1:0] {
      TCB_M3100_M1800 = 2'b00,
      TCB_M1750_M550 = 2'b10,
      TCB_M550_P450 = 2'b01,
      TCB_P450_P1000 = 2'b11
   } tc_band_t;

   // Gray sequence along idle, fetch, exec, answer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b11,
      ST_ANSWER = 2'b10
   } cmd_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } supply_cmd_t;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } answer_t;

   typedef struct packed {
      field_range_t field_range;
      logic [2:0] filter_sel;
      tc_band_t temp_coeff_band;
      logic [DATA_W-1:0] temp_coeff_linear;
      logic [DATA_W-1:0] temp_coeff_quadratic;
      logic [GAIN_W-1:0] gain;
      logic [OFFSET_W-1:0] zero_field_offset;
      logic [CLO_W-1:0] clamp_low;
      logic [CHI_W-1:0] clamp_high;
      logic [DATA_W-1:0] factory_trim;
   } param_set_t;

   typedef logic [N_WORDS-1:0][DATA_W-1:0] word_array_t;
endpackage : hall_store_pkg
`default_nettype wire

// ==== src/nv_param_mem.sv ====
`default_nettype none
module nv_param_mem (
   input wire logic i_clk_sys,
   input wire logic i_nv_blank_n,
   input wire logic i_we,
   input wire logic [hall_store_pkg::ADDR_W-1:0] i_waddr,
   input wire logic [hall_store_pkg::DATA_W-1:0] i_wdata,
   input wire logic [hall_store_pkg::ADDR_W-1:0] i_raddr,
   output logic [hall_store_pkg::DATA_W-1:0] o_rdata,
   output hall_store_pkg::word_array_t o_words
);
   import hall_store_pkg::*;

   word_array_t mem_r;
   logic [DATA_W-1:0] rdata_r;
   logic raddr_ok;

   // Cells hold through the logic reset; only a blank start clears them
   for (genvar g = 0; g < N_WORDS; g++) begin : g_word
      always_ff @(posedge i_clk_sys or negedge i_nv_blank_n) begin
         if (!i_nv_blank_n) begin
            mem_r[g] <= WORD_RST;
         end else if (i_we && (i_waddr == ADDR_W'(g))) begin
            mem_r[g] <= i_wdata;
         end
      end
   end

   assign raddr_ok = (i_raddr < ADDR_W'(N_WORDS));

   // Registered read port
   always_ff @(posedge i_clk_sys or negedge i_nv_blank_n) begin
      if (!i_nv_blank_n) begin
         rdata_r <= WORD_RST;
      end else begin
         rdata_r <= raddr_ok ? mem_r[i_raddr] : WORD_RST;
      end
   end

   assign o_rdata = rdata_r;
   assign o_words = mem_r;
endmodule : nv_param_mem
`default_nettype wire

// ==== src/hall_param_store.sv ====
`default_nettype none
module hall_param_store (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_nv_blank_n,
   input wire logic i_supply_in_band,
   input wire logic i_pin_selected,
   input wire hall_store_pkg::supply_cmd_t i_cmd,
   input wire logic i_field_valid,
   input wire logic [hall_store_pkg::FIELD_W-1:0] i_field,
   output logic o_analog_enable,
   output hall_store_pkg::answer_t o_answer,
   output hall_store_pkg::param_set_t o_params,
   output logic [hall_store_pkg::OUT_W-1:0] o_processed,
   output logic o_lock_active
);
   import hall_store_pkg::*;

   cmd_state_t state_r;
   cmd_state_t state_nxt;
   supply_cmd_t cmd_r;
   logic [DATA_W-1:0] ans_data_r;
   logic [DATA_W-1:0] ans_data_nxt;
   logic captured_r;
   logic lock_active_r;
   param_set_t params_r;
   param_set_t params_nxt;
   logic [OUT_W-1:0] readout_r;

   logic accept_w;
   logic mem_we;
   logic [DATA_W-1:0] mem_wdata;
   logic [DATA_W-1:0] mem_rdata;
   word_array_t mem_words;
   logic addr_mapped_w;
   logic addr_writable_w;
   logic is_lock_addr_w;
   logic [LOCK_W-1:0] lock_bits_w;
   logic [1:0] wr_range_w;

   logic signed [PROD_W-1:0] prod_w;
   logic signed [PROD_W-PROD_SHIFT-1:0] scaled_w;
   logic signed [SUM_W-1:0] sum_w;
   logic signed [SUM_W-1:0] floor_w;
   logic signed [SUM_W-1:0] ceil_w;
   logic signed [SUM_W-1:0] above_w;
   logic signed [SUM_W-1:0] clamped_w;

   // Non-volatile parameter store
   nv_param_mem u_mem (
      .i_clk_sys(i_clk_sys),
      .i_nv_blank_n(i_nv_blank_n),
      .i_we(mem_we),
      .i_waddr(cmd_r.addr),
      .i_wdata(mem_wdata),
      .i_raddr(cmd_r.addr),
      .o_rdata(mem_rdata),
      .o_words(mem_words)
   );

   // Analog output only while supply sits in the normal band
   assign o_analog_enable = i_supply_in_band;

   // Command acceptance: out of band, selected, not locked, idle
   assign accept_w = i_cmd.valid && !i_supply_in_band
                     && i_pin_selected
                     && captured_r && !lock_active_r
                     && (state_r == ST_IDLE);

   // Address decode over the three groups
   assign addr_mapped_w = (cmd_r.addr <= ADDR_TRIM);
   assign is_lock_addr_w = (cmd_r.addr == ADDR_LOCK);
   assign addr_writable_w = addr_mapped_w && (cmd_r.addr != ADDR_READOUT);

   // Write in exec; lock bits only ever set, never cleared
   assign mem_we = (state_r == ST_EXEC) && cmd_r.write && addr_writable_w && !lock_active_r;
   assign mem_wdata = is_lock_addr_w ?
                      (mem_rdata | {{(DATA_W-LOCK_W){1'b0}}, cmd_r.data[LOCK_W-1:0]}) :
                      cmd_r.data;

   // Answer word: written value, readout, stored word or zero
   assign ans_data_nxt = (cmd_r.write && addr_writable_w) ? mem_wdata :
                         (cmd_r.addr == ADDR_READOUT) ?
                         {{(DATA_W-OUT_W){1'b0}}, readout_r} :
                         addr_mapped_w ? mem_rdata : WORD_RST;

   // Command sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (accept_w) begin
               state_nxt = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_nxt = ST_EXEC;
         end
         ST_EXEC: begin
            state_nxt = ST_ANSWER;
         end
         ST_ANSWER: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer state and latched command
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
         cmd_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (accept_w) begin
            cmd_r <= i_cmd;
         end
      end
   end

   // Answer data register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ans_data_r <= WORD_RST;
      end else if (state_r == ST_EXEC) begin
         ans_data_r <= ans_data_nxt;
      end
   end

   assign o_answer = '{valid: (state_r == ST_ANSWER), data: ans_data_r};

   // Lock sampled once after power-up release only
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         captured_r <= 1'b0;
         lock_active_r <= 1'b0;
      end else if (!captured_r) begin
         captured_r <= 1'b1;
         lock_active_r <= lock_bits_w[LOCK_BIT];
      end
   end

   assign lock_bits_w = mem_words[ADDR_LOCK][LOCK_W-1:0];
   assign o_lock_active = lock_active_r;

   // Unpack stored words into the processing settings
   assign params_nxt = '{
      field_range: field_range_t'(mem_words[ADDR_MODE][MODE_RANGE_MSB:MODE_RANGE_LSB]),
      filter_sel: mem_words[ADDR_MODE][MODE_FILT_MSB:MODE_FILT_LSB],
      temp_coeff_band: tc_band_t'(mem_words[ADDR_TC_BAND][1:0]),
      temp_coeff_linear: mem_words[ADDR_TC_LIN],
      temp_coeff_quadratic: mem_words[ADDR_TC_QUAD],
      gain: mem_words[ADDR_GAIN][GAIN_W-1:0],
      zero_field_offset: mem_words[ADDR_OFFSET][OFFSET_W-1:0],
      clamp_low: mem_words[ADDR_CLAMP_LO][CLO_W-1:0],
      clamp_high: mem_words[ADDR_CLAMP_HI][CHI_W-1:0],
      factory_trim: mem_words[ADDR_TRIM]
   };

   // Settings register toward the signal path
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         params_r <= '0;
      end else begin
         params_r <= params_nxt;
      end
   end

   assign o_params = params_r;

   // Multiply, add, then clamp between floor and ceiling
   assign prod_w = $signed(i_field) * $signed(params_r.gain);
   assign scaled_w = prod_w[PROD_W-1:PROD_SHIFT];
   assign sum_w = {scaled_w[PROD_W-PROD_SHIFT-1], scaled_w}
                  + {{(SUM_W-OFFSET_W){params_r.zero_field_offset[OFFSET_W-1]}},
                     params_r.zero_field_offset};
   assign floor_w = {{(SUM_W-CLO_W-1){1'b0}}, params_r.clamp_low, 1'b0};
   assign ceil_w = {{(SUM_W-CHI_W-1){1'b0}}, params_r.clamp_high, 1'b0};
   assign above_w = (sum_w < floor_w) ? floor_w : sum_w;
   assign clamped_w = (above_w > ceil_w) ? ceil_w : above_w;

   // Processed value register, also the readout source
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         readout_r <= OUT_RST;
      end else if (i_field_valid) begin
         readout_r <= clamped_w[OUT_W-1:0];
      end
   end

   assign o_processed = readout_r;
   assign wr_range_w = mem_wdata[MODE_RANGE_MSB:MODE_RANGE_LSB];

   // Checks
   answer_time_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      accept_w |-> ##3 (o_answer.valid && !$past(o_answer.valid)))
      else $error("answer not three cycles after accept");

   band_ignore_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_cmd.valid && i_supply_in_band && state_r == ST_IDLE) |=> (state_r == ST_IDLE))
      else $error("command taken while supply in band");

   select_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_cmd.valid && !i_pin_selected && state_r == ST_IDLE) |=> (state_r == ST_IDLE))
      else $error("unselected device took a command");

   locked_silent_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      lock_active_r |-> (!o_answer.valid && (state_r == ST_IDLE)))
      else $error("locked device answered");

   lock_defer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (captured_r && $past(captured_r)) |-> $stable(lock_active_r))
      else $error("lock changed without power cycle");

   lock_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mem_we && is_lock_addr_w) |=> ((lock_bits_w & $past(lock_bits_w)) == $past(lock_bits_w)))
      else $error("lock bit cleared");

   no_locked_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      lock_active_r |-> !mem_we [*4])
      else $error("store written while locked");

   range_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mem_we && cmd_r.addr == ADDR_MODE) |-> ##2 (o_params.field_range == $past(wr_range_w, 2)))
      else $error("range field not taken from mode bits 2:1");

   clamp_bound_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_field_valid && (floor_w <= ceil_w)) |=>
      ((SUM_W'(o_processed) >= $past(floor_w)) && (SUM_W'(o_processed) <= $past(ceil_w))))
      else $error("processed value outside clamps");

   // Sequencer walks fetch, exec, answer, idle with one answer pulse
   answer_once_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_answer.valid |=> !o_answer.valid)
      else $error("answer longer than one cycle");

   fetch_to_exec_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_r == ST_FETCH) |=> (state_r == ST_EXEC))
      else $error("fetch not followed by exec");

   exec_to_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_r == ST_EXEC) |=> (state_r == ST_ANSWER))
      else $error("exec not followed by answer");

   answer_to_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_r == ST_ANSWER) |=> (state_r == ST_IDLE))
      else $error("answer not followed by idle");

   // No command taken while busy or locked
   busy_refuse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_r != ST_IDLE) |-> !accept_w)
      else $error("command taken during a transfer");

   locked_no_take_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      lock_active_r |-> !accept_w)
      else $error("locked device took a command");

   // Store writes only in exec, never to readout or unmapped words
   write_in_exec_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      mem_we |-> ((state_r == ST_EXEC) && cmd_r.write))
      else $error("store written outside a write exec");

   readout_readonly_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      mem_we |-> (cmd_r.addr != ADDR_READOUT))
      else $error("readout word written");

   unmapped_readonly_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      mem_we |-> (cmd_r.addr <= ADDR_TRIM))
      else $error("unmapped word written");

   lock_merge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mem_we && is_lock_addr_w) |-> ((mem_wdata & mem_rdata) == mem_rdata))
      else $error("lock write would clear a bit");

   // Answer data carries the written word or the readout
   write_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      mem_we |=> (o_answer.data == $past(mem_wdata)))
      else $error("write answer differs from stored word");

   readout_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ((state_r == ST_EXEC) && (cmd_r.addr == ADDR_READOUT)) |=>
      (o_answer.data == {{(DATA_W-OUT_W){1'b0}}, $past(readout_r)}))
      else $error("readout answer differs from processed value");

   readout_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_field_valid |=> $stable(o_processed))
      else $error("processed value moved without a sample");

   lock_capture_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !captured_r |=> (lock_active_r == $past(lock_bits_w[LOCK_BIT])))
      else $error("lock not captured at first edge");

   // Settings follow the store two edges after a write
   band_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mem_we && (cmd_r.addr == ADDR_TC_BAND)) |-> ##2
      (o_params.temp_coeff_band == $past(mem_wdata[1:0], 2)))
      else $error("band field not taken from bits 1:0");

   gain_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mem_we && (cmd_r.addr == ADDR_GAIN)) |-> ##2
      (o_params.gain == $past(mem_wdata[GAIN_W-1:0], 2)))
      else $error("gain field not taken from store");

   filter_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mem_we && (cmd_r.addr == ADDR_MODE)) |-> ##2
      (o_params.filter_sel == $past(mem_wdata[MODE_FILT_MSB:MODE_FILT_LSB], 2)))
      else $error("filter field not taken from mode bits");
endmodule : hall_param_store
`default_nettype wire

// ==== tb/prog_model.sv ====
`default_nettype none
// Programmer on the far side: modulates supply, selects the pin, reads answers
module prog_model (
   input wire logic i_clk_sys,
   input wire hall_store_pkg::answer_t i_answer,
   output hall_store_pkg::supply_cmd_t o_cmd,
   output logic o_in_band,
   output logic o_selected
);
   timeunit 1ns;
   timeprecision 100ps;
   import hall_store_pkg::*;

   // Idle: supply out of band, this device selected
   initial begin
      o_cmd = '0;
      o_in_band = 1'b0;
      o_selected = 1'b1;
   end

   // One command pulse, then watch cycles 1..5 for the answer
   task automatic send(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       output logic got, output int hits, output logic [15:0] q);
      @(posedge i_clk_sys);
      #1;
      o_cmd = '{valid: 1'b1, write: wr, addr: a, data: d};
      @(posedge i_clk_sys);
      #1;
      o_cmd = '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d}; // Released lines flip
      got = 1'b0;
      hits = 0;
      q = 16'h0000;
      for (int n = 1; n < 6; n++) begin
         if (n > 1) begin
            @(posedge i_clk_sys);
            #1;
         end
         if (i_answer.valid !== 1'b0) begin // An unknown counts as an answer
            hits++;
            if (n == 3 && i_answer.valid === 1'b1) begin
               got = 1'b1;
               q = i_answer.data;
            end
         end
      end
   endtask : send
endmodule : prog_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import hall_store_pkg::*;

   logic clk_sys;
   logic rst_n;
   logic blank_n;
   logic fvalid;
   logic [15:0] field;
   supply_cmd_t cmd;
   answer_t ans;
   logic in_band;
   logic sel;
   logic analog_en;
   param_set_t prm;
   logic [9:0] proc_v;
   logic lock_on;
   int bad_count;
   int tests_run;
   logic got;
   int hits;
   logic [15:0] q;

   hall_param_store i_dut (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_nv_blank_n(blank_n),
      .i_supply_in_band(in_band), .i_pin_selected(sel), .i_cmd(cmd),
      .i_field_valid(fvalid), .i_field(field), .o_analog_enable(analog_en),
      .o_answer(ans), .o_params(prm), .o_processed(proc_v), .o_lock_active(lock_on)
   );

   prog_model i_prog (
      .i_clk_sys(clk_sys), .i_answer(ans), .o_cmd(cmd), .o_in_band(in_band),
      .o_selected(sel)
   );

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk

   // Accepted transfer: one answer in cycle 3 carrying e
   task automatic rw(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     input logic [15:0] e);
      i_prog.send(wr, a, d, got, hits, q);
      chk(got === 1'b1 && hits == 1 && q === e, "answer wrong or missing");
   endtask : rw

   // Dropped transfer: no answer at all
   task automatic drop(input logic wr, input logic [3:0] a);
      i_prog.send(wr, a, 16'h0000, got, hits, q);
      chk(hits == 0, "answer to a dropped command");
   endtask : drop

   // One field sample, result checked the cycle after
   task automatic fld(input logic [15:0] f, input logic [9:0] e);
      @(posedge clk_sys);
      #1;
      field = f;
      fvalid = 1'b1;
      @(posedge clk_sys);
      #1;
      fvalid = 1'b0;
      field = ~f;
      chk(proc_v === e, "processed value");
   endtask : fld

   // Power cycle: reset pulse, then two edges before commands
   task automatic pwr();
      @(posedge clk_sys);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : pwr

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      final_report();
   end

   // Main sequence
   initial begin
      bad_count = 0;
      tests_run = 0;
      rst_n = 1'b0;
      blank_n = 1'b0;
      fvalid = 1'b0;
      field = 16'h0000;
      repeat (2) @(posedge clk_sys);
      #1;
      blank_n = 1'b1;
      repeat (14) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(prm === '0 && proc_v === 10'h000 && lock_on === 1'b0, "reset values");
      // Every range and band code
      for (int k = 0; k < 4; k++) begin
         rw(1'b1, ADDR_MODE, 16'(k << 1), 16'(k << 1));
         chk(prm.field_range === field_range_t'(2'(k)), "range field");
         rw(1'b1, ADDR_TC_BAND, 16'(k), 16'(k));
         chk(prm.temp_coeff_band === tc_band_t'(2'(k)), "band field");
      end
      rw(1'b1, ADDR_TC_LIN, 16'hA55A, 16'hA55A);
      rw(1'b1, ADDR_TC_QUAD, 16'h3C96, 16'h3C96);
      chk(prm.temp_coeff_linear === 16'hA55A &&
          prm.temp_coeff_quadratic === 16'h3C96, "temperature terms");
      rw(1'b1, ADDR_MODE, 16'h002A, 16'h002A);
      chk(prm.filter_sel === 3'h5 && prm.field_range === RANGE_60MT, "mode fields");
      rw(1'b1, ADDR_GAIN, 16'h0800, 16'h0800);
      rw(1'b1, ADDR_OFFSET, 16'h0003, 16'h0003);
      rw(1'b1, ADDR_CLAMP_LO, 16'h0000, 16'h0000);
      rw(1'b1, ADDR_CLAMP_HI, 16'h01FF, 16'h01FF);
      chk(prm.gain === 14'h0800 && prm.zero_field_offset === 11'h003, "gain/offset");
      chk(prm.clamp_low === 8'h00 && prm.clamp_high === 9'h1FF, "clamps");
      rw(1'b0, ADDR_GAIN, 16'h0000, 16'h0800);
      // Field path, readout, clamping
      fld(16'h4000, 10'd259);
      rw(1'b0, ADDR_READOUT, 16'h0000, 16'd259);
      rw(1'b1, ADDR_CLAMP_LO, 16'h0040, 16'h0040);
      fld(16'hC000, 10'd128);
      rw(1'b1, ADDR_CLAMP_HI, 16'h0080, 16'h0080);
      fld(16'h7FFF, 10'd256);
      // Readout refuses a write and answers the processed value
      rw(1'b1, ADDR_READOUT, 16'h0155, 16'd256);
      // Unmapped word stores nothing and reads zero
      rw(1'b1, 4'hB, 16'hFFFF, 16'h0000);
      rw(1'b0, 4'hB, 16'h0000, 16'h0000);
      // In band and unselected commands are dropped
      i_prog.o_in_band = 1'b1;
      #1;
      chk(analog_en === 1'b1, "analog mode in band");
      drop(1'b1, ADDR_GAIN);
      i_prog.o_in_band = 1'b0;
      i_prog.o_selected = 1'b0;
      #1;
      chk(analog_en === 1'b0, "analog mode off");
      drop(1'b1, ADDR_GAIN);
      i_prog.o_selected = 1'b1;
      rw(1'b0, ADDR_GAIN, 16'h0000, 16'h0800);
      // Lock: set wins, not in force until the next power cycle
      rw(1'b1, ADDR_LOCK, 16'h0001, 16'h0001);
      rw(1'b1, ADDR_LOCK, 16'h0000, 16'h0001);
      rw(1'b1, ADDR_TRIM, 16'h5A5A, 16'h5A5A);
      chk(lock_on === 1'b0, "lock early");
      pwr();
      chk(lock_on === 1'b1, "lock after power cycle");
      chk(prm.gain === 14'h0800 && prm.factory_trim === 16'h5A5A, "store kept");
      drop(1'b0, ADDR_GAIN);
      drop(1'b1, ADDR_GAIN);
      chk(prm.gain === 14'h0800, "write while locked");
      pwr();
      chk(lock_on === 1'b1, "lock permanent");
      drop(1'b1, ADDR_LOCK);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
